// >>> bench/debug_break_watch_checker.sv
`timescale 1ns/1ps
`default_nettype none
// bus and interrupt relations seen at the block's pins
module debug_break_watch_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pc_valid,
  input wire logic mem_valid,
  input wire logic res_valid,
  input wire logic debug_take,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase, and any pipeline event this cycle
  wire logic a = psel && penable;
  wire logic e = pc_valid || mem_valid || res_valid;
  AST_READY: assert property (a |-> pready) else $error("no ready");
  AST_UNMAP: assert property (a && !pwrite && paddr[11:10] == 2'h3 |-> pslverr && !prdata) else $error("unmap");
  AST_IB_RSVD: assert property (a && paddr[11:4] == 8'h10 |-> !(prdata & 32'hFF00FFFC)) else $error("ib");
  AST_DW_RSVD: assert property (a && paddr[11:4] == 8'h1C |-> !(prdata & 32'hFF00FFF8)) else $error("dw");
  AST_RW_RSVD: assert property (a && paddr[11:4] == 8'h27 |-> !(prdata & 32'hFF00FFFC)) else $error("rw");
  AST_IRQ_MASK: assert property (a && pwrite && paddr == 12'h284 && !pwdata[2:0] |=> !irq) else $error("mask");
  AST_IRQ_CLR: assert property (a && pwrite && paddr == 12'h280 && &pwdata[2:0] && !e |=> !irq) else $error("clr");
  AST_TAKE: assert property (debug_take |-> $past(e)) else $error("take without event");
endmodule
bind debug_break_watch_unit debug_break_watch_checker debug_break_watch_checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pc_valid(pc_valid), .mem_valid(mem_valid), .res_valid(res_valid),
  .debug_take(debug_take), .irq(irq));
`default_nettype wire

// >>> bench/debug_break_watch_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module debug_break_watch_unit_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, a1, dat;
  logic pready, pslverr, sl, debug_take, irq, ld;
  logic [2:0] debug_thread, vld, thr, t;
  logic [11:0] ca [3] = '{12'h100, 12'h1C0, 12'h270};
  logic [31:0] wm [3] = '{32'h00FF0003, 32'h00FF0007, 32'h00FF0003};
  int failures = 0, n_compared = 0, i;
  // 25 MHz clock
  always #20 pclk = ~pclk;
  debug_break_watch_unit debug_break_watch_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pc_valid(vld[0]), .pc_value(dat), .pc_thread(thr), .mem_valid(vld[1]),
    .mem_is_load(ld), .mem_addr(dat), .mem_thread(thr), .res_valid(vld[2]), .res_id(dat), .res_thread(thr),
    .debug_take(debug_take), .debug_thread(debug_thread), .irq(irq));
  pipe_model pipe_model_i (.pclk(pclk), .vld(vld), .dat(dat), .thr(thr), .ld(ld));
  // expected control word and cause word
  function automatic logic [31:0] en(input logic [2:0] f);
    return {8'h00, 8'h01 << t, 13'h0000, f};
  endfunction
  function automatic logic [31:0] cz(input logic [1:0] n, input logic [2:0] c);
    return {14'h0000, n, 5'h00, t, 5'h00, c};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer; read data taken at the ready edge
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    {psel, penable} <= 2'h0;
    #1;
  endtask
  // one event, then the pulse, thread and cause word
  task automatic hit(input logic [1:0] k, input logic [31:0] d, input logic [2:0] h, input logic l,
                     input logic [31:0] x);
    pipe_model_i.ev(k, d, h, l);
    #1 chk(debug_take, x != 0);
    if (x != 0) begin
      chk(debug_thread, h);
      xf(1'b0, 12'h054, 0);
      chk(rd, x);
    end
  endtask
  task automatic summarize;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h7542F6D9));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    v = $urandom;
    t = 3'($urandom);
    a1 = $urandom;
    for (i = 0; i < 3; i++) begin
      xf(1'b0, ca[i], 0);
      chk(rd, 0);
      xf(1'b1, ca[i], '1);
      xf(1'b0, ca[i], 0);
      chk(rd, wm[i]);
      xf(1'b1, ca[i], 0);
    end
    xf(1'b0, 12'hFFC, 0);
    chk(sl, 1);
    $display("test registers done");
    // same address in all four units, unit 0 left disabled
    for (i = 0; i < 4; i++) begin
      xf(1'b1, 12'(12'h0C0 + 4 * i), v);
      xf(1'b1, 12'(12'h100 + 4 * i), en({2'h0, i > 0}));
    end
    hit(0, v, t, 0, cz(2'h1, 3'h3));
    hit(0, v, t + 3'h1, 0, 0);
    hit(0, ~v, t, 0, 0);
    xf(1'b1, 12'h104, en(3'h3));
    hit(0, ~v, t, 0, cz(2'h1, 3'h3));
    hit(0, v, t, 0, cz(2'h2, 3'h3));
    for (i = 0; i < 4; i++) xf(1'b1, 12'(12'h100 + 4 * i), 0);
    $display("test instruction done");
    // data unit 3, either address, loads only
    xf(1'b1, 12'h14C, a1);
    xf(1'b1, 12'h18C, a1 ^ 32'h4);
    xf(1'b1, 12'h1CC, en(3'h7));
    xf(1'b0, 12'h14C, 0);
    chk(rd, a1);
    hit(1, a1 ^ 32'h4, t, 1, cz(2'h3, 3'h4));
    xf(1'b0, 12'h058, 0);
    chk(rd, a1 ^ 32'h4);
    hit(1, a1, t, 0, 0);
    xf(1'b1, 12'h1CC, en(3'h1));
    hit(1, a1, t, 0, 0);
    xf(1'b1, 12'h18C, a1);
    hit(1, a1, t, 1, 0);
    hit(1, a1, t, 0, cz(2'h3, 3'h4));
    $display("test data done");
    // resource unit 0 compares the upper half only
    xf(1'b1, 12'h200, 32'hFFFF0000);
    xf(1'b1, 12'h240, v & 32'hFFFF0000);
    xf(1'b1, 12'h270, en(3'h1));
    hit(2, v, t, 0, cz(2'h0, 3'h5));
    xf(1'b0, 12'h058, 0);
    chk(rd, v);
    xf(1'b1, 12'h270, en(3'h3));
    hit(2, v, t, 0, 0);
    hit(2, v ^ 32'h10000, t, 0, cz(2'h0, 3'h5));
    $display("test resource done");
    // all three kinds pending: masked, unmasked, cleared
    xf(1'b1, 12'h284, 0);
    chk(irq, 0);
    xf(1'b0, 12'h280, 0);
    chk(rd, 7);
    xf(1'b1, 12'h284, 7);
    chk(irq, 1);
    xf(1'b1, 12'h280, 7);
    chk(irq, 0);
    $display("test interrupt done");
    summarize;
  end
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    failures++;
    summarize;
  end
endmodule
`default_nettype wire

// >>> bench/pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// pipeline stand-in: one event per call, one cycle long
module pipe_model (
  input wire logic pclk,
  output logic [2:0] vld,
  output logic [31:0] dat,
  output logic [2:0] thr,
  output logic ld
);
  initial {vld, dat, thr, ld} = 39'h0;
  // idle lines carry inverted values so a stale match cannot slip through
  task automatic ev(input logic [1:0] k, input logic [31:0] d, input logic [2:0] t, input logic l);
    @(posedge pclk);
    {vld, dat, thr, ld} <= {3'h1 << k, d, t, l};
    @(posedge pclk);
    {vld, dat, thr, ld} <= {3'h0, ~d, ~t, ~l};
  endtask
endmodule
`default_nettype wire

// >>> hdl/debug_break_watch_consts.vh
`ifndef DEBUG_BREAK_WATCH_CONSTS_VH
`define DEBUG_BREAK_WATCH_CONSTS_VH

// register indices; the byte address is four times the index
`define IDX_CAUSE 10'h015
`define IDX_CAUSE_DATA 10'h016
`define IDX_IB_ADDR 10'h030
`define IDX_IB_CTRL 10'h040
`define IDX_DW_FIRST 10'h050
`define IDX_DW_SECOND 10'h060
`define IDX_DW_CTRL 10'h070
`define IDX_RW_MASK 10'h080
`define IDX_RW_VALUE 10'h090
`define IDX_RW_CTRL 10'h09C
`define IDX_IRQ_STATUS 10'h0A0
`define IDX_IRQ_MASK 10'h0A1

// control field positions
`define CTRL_EN_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_LOAD_BIT 2
`define CTRL_THR_LSB 16
`define CTRL_THR_MSB 23

// writable bits of each control register
`define IB_CTRL_WMASK 32'h00FF0003
`define DW_CTRL_WMASK 32'h00FF0007
`define RW_CTRL_WMASK 32'h00FF0003

// reset values
`define CTRL_RESET 32'h00000000
`define DATA_RESET 32'h00000000
`define IRQ_RESET 3'h0

// cause codes
`define CAUSE_INSTR 3'h3
`define CAUSE_DATA 3'h4
`define CAUSE_RES 3'h5

`endif

// >>> hdl/debug_break_watch_unit.v
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "debug_break_watch_consts.vh"

// Overview of operation
// - four instruction breakpoints, each with its own control register.
// - bit 0 enables each comparator; disabled never fires; controls reset to zero.
// - bits 23:16 hold a per-thread mask; only masked-in threads fire.
// - instruction mode bit 1: 0 fires on equal PC, 1 on differing PC.
// - each data watchpoint has first and second 32-bit address registers.
// - each data watchpoint has its own control register.
// - data control bit 2: 1 fires on loads only, 0 on stores only.
// - data control bit 1: 0 needs A and B, 1 needs A or B.
// - each resource watchpoint has a 32-bit mask register.
// - each resource watchpoint has a 32-bit value compared with masked identifier.
// - each resource watchpoint has a control register: enable, thread mask, condition.
// - resource control bit 1: 0 fires on condition A, 1 on condition B.
// - an enabled matching instruction breakpoint raises a debug interrupt for the thread.
// - cause code recorded: 3 instruction, 4 data, 5 resource.
// - data hit captures effective address; resource hit captures resource identifier.
module debug_break_watch_unit (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire pc_valid,
  input wire [31:0] pc_value,
  input wire [2:0] pc_thread,
  input wire mem_valid,
  input wire mem_is_load,
  input wire [31:0] mem_addr,
  input wire [2:0] mem_thread,
  input wire res_valid,
  input wire [31:0] res_id,
  input wire [2:0] res_thread,
  output reg debug_take,
  output reg [2:0] debug_thread,
  output wire irq
);

  // instruction breakpoint address and control, one word per unit
  reg [31:0] ib_addr_reg [0:3];
  reg [31:0] ib_ctrl_reg [0:3];

  // data watchpoint addresses and control, one word per unit
  reg [31:0] dw_first_reg [0:3];
  reg [31:0] dw_second_reg [0:3];
  reg [31:0] dw_ctrl_reg [0:3];

  // resource watchpoint mask, value and control, one word per unit
  reg [31:0] rw_mask_reg [0:3];
  reg [31:0] rw_value_reg [0:3];
  reg [31:0] rw_ctrl_reg [0:3];

  // cause of the latest reported hit
  reg [2:0] cause_code_reg;
  reg [1:0] cause_num_reg;
  reg [2:0] cause_thread_reg;
  reg [31:0] cause_data_reg;

  // interrupt status and mask, one bit per kind of hit
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;

  wire [9:0] idx = paddr[11:2];
  wire [9:0] grp = {idx[9:2], 2'b00};
  wire [1:0] sub = idx[1:0];
  wire wr_en = psel && penable && pwrite;
  wire [3:0] ib_hit;
  wire [3:0] dw_hit;
  wire [3:0] rw_hit;

  // thread filter shared by every comparator
  function thread_ok;
    input [31:0] ctrl;
    input [2:0] thr;
    begin
      thread_ok = ctrl[`CTRL_EN_BIT] && ctrl[`CTRL_THR_LSB + thr];
    end
  endfunction

  // lowest set bit wins when several units fire together
  function [1:0] lowest;
    input [3:0] v;
    begin
      if (v[0]) begin
        lowest = 2'h0;
      end else if (v[1]) begin
        lowest = 2'h1;
      end else if (v[2]) begin
        lowest = 2'h2;
      end else begin
        lowest = 2'h3;
      end
    end
  endfunction

  // known register index, used by the error answer only; the read mux decodes on its own
  function mapped;
    input [9:0] a;
    input [9:0] g;
    begin
      mapped = (a == `IDX_CAUSE) || (a == `IDX_CAUSE_DATA) || (a == `IDX_IRQ_STATUS) ||
               (a == `IDX_IRQ_MASK) || (g == `IDX_IB_ADDR) || (g == `IDX_IB_CTRL) ||
               (g == `IDX_DW_FIRST) || (g == `IDX_DW_SECOND) || (g == `IDX_DW_CTRL) ||
               (g == `IDX_RW_MASK) || (g == `IDX_RW_VALUE) || (g == `IDX_RW_CTRL);
    end
  endfunction

  // per-unit comparators
  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_unit
      wire pc_eq = (pc_value == ib_addr_reg[n]);
      wire pc_cmp = ib_ctrl_reg[n][`CTRL_MODE_BIT] ? !pc_eq : pc_eq;
      assign ib_hit[n] = pc_valid && thread_ok(ib_ctrl_reg[n], pc_thread) && pc_cmp;
      wire cond_a = (mem_addr == dw_first_reg[n]);
      wire cond_b = (mem_addr == dw_second_reg[n]);
      wire dw_cmp = dw_ctrl_reg[n][`CTRL_MODE_BIT] ? (cond_a || cond_b) : (cond_a && cond_b);
      wire kind_ok = mem_is_load ? dw_ctrl_reg[n][`CTRL_LOAD_BIT] : !dw_ctrl_reg[n][`CTRL_LOAD_BIT];
      assign dw_hit[n] = mem_valid && thread_ok(dw_ctrl_reg[n], mem_thread) && kind_ok && dw_cmp;
      wire res_eq = ((res_id & rw_mask_reg[n]) == rw_value_reg[n]);
      wire rw_cmp = rw_ctrl_reg[n][`CTRL_MODE_BIT] ? !res_eq : res_eq;
      assign rw_hit[n] = res_valid && thread_ok(rw_ctrl_reg[n], res_thread) && rw_cmp;
    end
  endgenerate

  wire any_ib = |ib_hit;
  wire any_dw = |dw_hit;
  wire any_rw = |rw_hit;
  wire any_hit = any_ib || any_dw || any_rw;

  // write strobe of one register group, shared by every array below
  function grp_wr;
    input w;
    input [9:0] g;
    input [9:0] base;
    begin
      grp_wr = w && (g == base);
    end
  endfunction

  // instruction addresses; one process per array keeps each array single-driven
  always @(posedge pclk or negedge presetn) begin : p_ib_addr
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        ib_addr_reg[j] <= `DATA_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_IB_ADDR)) begin
      ib_addr_reg[sub] <= pwdata;
    end
  end

  // instruction controls; reserved bits never stored
  always @(posedge pclk or negedge presetn) begin : p_ib_ctrl
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        ib_ctrl_reg[j] <= `CTRL_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_IB_CTRL)) begin
      ib_ctrl_reg[sub] <= pwdata & `IB_CTRL_WMASK;
    end
  end

  // first data addresses
  always @(posedge pclk or negedge presetn) begin : p_dw_first
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        dw_first_reg[j] <= `DATA_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_DW_FIRST)) begin
      dw_first_reg[sub] <= pwdata;
    end
  end

  // second data addresses
  always @(posedge pclk or negedge presetn) begin : p_dw_second
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        dw_second_reg[j] <= `DATA_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_DW_SECOND)) begin
      dw_second_reg[sub] <= pwdata;
    end
  end

  // data controls; reserved bits never stored
  always @(posedge pclk or negedge presetn) begin : p_dw_ctrl
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        dw_ctrl_reg[j] <= `CTRL_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_DW_CTRL)) begin
      dw_ctrl_reg[sub] <= pwdata & `DW_CTRL_WMASK;
    end
  end

  // resource masks
  always @(posedge pclk or negedge presetn) begin : p_rw_mask
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        rw_mask_reg[j] <= `DATA_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_RW_MASK)) begin
      rw_mask_reg[sub] <= pwdata;
    end
  end

  // resource values
  always @(posedge pclk or negedge presetn) begin : p_rw_value
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        rw_value_reg[j] <= `DATA_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_RW_VALUE)) begin
      rw_value_reg[sub] <= pwdata;
    end
  end

  // resource controls; reserved bits never stored
  always @(posedge pclk or negedge presetn) begin : p_rw_ctrl
    integer j;
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        rw_ctrl_reg[j] <= `CTRL_RESET;
      end
    end else if (grp_wr(wr_en, grp, `IDX_RW_CTRL)) begin
      rw_ctrl_reg[sub] <= pwdata & `RW_CTRL_WMASK;
    end
  end

  // interrupt mask, only three bits exist
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `IRQ_RESET;
    end else if (wr_en && idx == `IDX_IRQ_MASK) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  // next cause values; instruction beats data beats resource in one cycle
  reg [2:0] cause_code_next;
  reg [1:0] cause_num_next;
  reg [2:0] cause_thread_next;
  reg [31:0] cause_data_next;
  always @* begin
    cause_code_next = cause_code_reg;
    cause_num_next = cause_num_reg;
    cause_thread_next = cause_thread_reg;
    cause_data_next = cause_data_reg; // an instruction hit leaves the old data in place
    if (any_ib) begin
      cause_code_next = `CAUSE_INSTR;
      cause_num_next = lowest(ib_hit);
      cause_thread_next = pc_thread;
    end else if (any_dw) begin
      cause_code_next = `CAUSE_DATA;
      cause_num_next = lowest(dw_hit);
      cause_thread_next = mem_thread;
      cause_data_next = mem_addr;
    end else if (any_rw) begin
      cause_code_next = `CAUSE_RES;
      cause_num_next = lowest(rw_hit);
      cause_thread_next = res_thread;
      cause_data_next = res_id;
    end
  end

  // cause registers and the one-cycle debug pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_code_reg <= 3'h0;
      cause_num_reg <= 2'h0;
      cause_thread_reg <= 3'h0;
      cause_data_reg <= `DATA_RESET;
      debug_take <= 1'b0;
      debug_thread <= 3'h0;
    end else begin
      debug_take <= any_hit;
      cause_code_reg <= cause_code_next;
      cause_num_reg <= cause_num_next;
      cause_thread_reg <= cause_thread_next;
      cause_data_reg <= cause_data_next;
      debug_thread <= cause_thread_next;
    end
  end

  // sticky status; a hit in the clearing cycle survives the clear
  wire [2:0] events = {any_rw, any_dw, any_ib};
  wire [2:0] clr = (wr_en && idx == `IDX_IRQ_STATUS) ? pwdata[2:0] : 3'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= `IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg & ~clr) | events;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // zero-wait slave; unmapped indices answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(idx, grp);

  // read mux, reserved bits come back zero
  always @* begin
    prdata = 32'h00000000;
    case (grp)
      `IDX_IB_ADDR: prdata = ib_addr_reg[sub];
      `IDX_IB_CTRL: prdata = ib_ctrl_reg[sub];
      `IDX_DW_FIRST: prdata = dw_first_reg[sub];
      `IDX_DW_SECOND: prdata = dw_second_reg[sub];
      `IDX_DW_CTRL: prdata = dw_ctrl_reg[sub];
      `IDX_RW_MASK: prdata = rw_mask_reg[sub];
      `IDX_RW_VALUE: prdata = rw_value_reg[sub];
      `IDX_RW_CTRL: prdata = rw_ctrl_reg[sub];
      default: begin
        // single registers outside the per-unit groups
        case (idx)
          `IDX_CAUSE: begin
            prdata = {14'h0000, cause_num_reg, 5'h00, cause_thread_reg, 5'h00, cause_code_reg};
          end
          `IDX_CAUSE_DATA: begin
            prdata = cause_data_reg;
          end
          `IDX_IRQ_STATUS: begin
            prdata = {29'h00000000, irq_status_reg};
          end
          `IDX_IRQ_MASK: begin
            prdata = {29'h00000000, irq_mask_reg};
          end
          default: begin
            prdata = 32'h00000000; // unmapped reads return zero
          end
        endcase
      end
    endcase
  end

endmodule
`default_nettype wire
